// [verilog/cfr_pkg.sv]
// Constants for the configuration register slice 0x0a to 0x0f
`default_nettype none
package cfr_pkg;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [7:0] IDX_ECP_IR = 8'h0a;
    localparam logic [7:0] IDX_VENDOR_B = 8'h0b;
    localparam logic [7:0] IDX_SERIAL = 8'h0c;
    localparam logic [7:0] IDX_DEV_ID = 8'h0d;
    localparam logic [7:0] IDX_REVISION = 8'h0e;
    localparam logic [7:0] IDX_TEST_ONE = 8'h0f;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ECP_THR_LSB = 0;
    localparam int ECP_THR_W = 4;
    localparam int IR_SEL_LSB = 6;
    localparam int IR_SEL_W = 2;
    localparam int RX_POL_BIT = 0;
    localparam int TX_POL_BIT = 1;
    localparam int DUPLEX_BIT = 2;
    localparam int MODE_LSB = 3;
    localparam int MODE_W = 3;
    localparam int HS1_BIT = 6;
    localparam int HS2_BIT = 7;
    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SERIAL = 8'h02;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] WMASK_ECP_IR = 8'hcf;
    localparam logic [7:0] WMASK_ALL = 8'hff;
    localparam logic [7:0] HMASK_ECP_IR = 8'hc0;
    localparam logic [7:0] HMASK_ALL = 8'hff;
    localparam logic [7:0] HMASK_NONE = 8'h00;
    // ----------------------------------------
    // Infrared route codes and serial modes
    // ----------------------------------------
    localparam logic [1:0] IR_SEL_RSVD0 = 2'h0;
    localparam logic [1:0] IR_SEL_ACTIVE = 2'h1;
    localparam logic [1:0] IR_SEL_RSVD2 = 2'h2;
    localparam logic [1:0] IR_SEL_INACTIVE = 2'h3;
    localparam logic [2:0] MODE_STD = 3'h0;
    localparam logic [2:0] MODE_SIR = 3'h1;
    localparam logic [2:0] MODE_ASK = 3'h2;
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage
`default_nettype wire

// [verilog/cfr_byte_reg.sv]
// One configuration byte with write mask and two reset sources
`timescale 1ns/1ps
`default_nettype none
module cfr_byte_reg #(
    parameter logic [7:0] POR_VALUE = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff,
    parameter logic [7:0] HARD_MASK = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hard_rst,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_q
);
    import cfr_pkg::*;

    typedef struct packed {
        logic [7:0] value;
    } cfr_byte_t;

    cfr_byte_t st;
    cfr_byte_t next_st;

    always_comb begin
        next_st = st;
        if (i_we) begin
            // Masked bits keep their value and so read back as stored
            next_st.value = (st.value & ~WR_MASK) | (i_wdata & WR_MASK);
        end
        if (i_hard_rst) begin
            next_st.value = (next_st.value & ~HARD_MASK) | (POR_VALUE & HARD_MASK);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '{value: POR_VALUE};
        end else begin
            st <= next_st;
        end
    end

    assign o_q = st.value;
endmodule
`default_nettype wire

// [verilog/cfr_ir_route.sv]
// Infrared line routing and polarity stage for serial port 2
`timescale 1ns/1ps
`default_nettype none
module cfr_ir_route (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_ir_route_select,
    input wire logic i_rx_active_low,
    input wire logic i_tx_active_low,
    input wire logic i_uart2_powered,
    input wire logic i_uart2_tx,
    input wire logic i_ir_receive_line,
    output logic o_ir_transmit_line,
    output logic o_ir_transmit_line_oe,
    output logic o_uart2_rx
);
    import cfr_pkg::*;

    typedef struct packed {
        logic tx;
        logic tx_oe;
        logic rx;
    } cfr_route_t;

    cfr_route_t st;
    cfr_route_t next_st;

    always_comb begin
        next_st = st;
        next_st.rx = i_ir_receive_line ^ i_rx_active_low;
        case (i_ir_route_select)
            IR_SEL_ACTIVE: begin
                next_st.tx_oe = 1'b1;
                // Powered-down port parks the line low, not at idle level
                next_st.tx = i_uart2_powered ? (i_uart2_tx ^ i_tx_active_low) : 1'b0;
            end
            IR_SEL_INACTIVE: begin
                next_st.tx_oe = 1'b0;
                next_st.tx = 1'b0;
            end
            default: begin
                // Reserved codes float the line, the safest guess
                next_st.tx_oe = 1'b0;
                next_st.tx = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '{tx: 1'b0, tx_oe: 1'b0, rx: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_ir_transmit_line = st.tx;
    assign o_ir_transmit_line_oe = st.tx_oe;
    assign o_uart2_rx = st.rx;
endmodule
`default_nettype wire

// [verilog/cfr_regs.sv]
// Configuration registers 0x0a to 0x0f behind the index/data ports
`timescale 1ns/1ps
`default_nettype none

// Function
// - Access only in config state, matching index
// - Bits 3:0 hold ECP FIFO threshold
// - ECP bits 5:4 unwritable, read zero
// - ECP register clears; route bits on hard reset
// - Route 01 drives IR; low when powered down
// - Route 11 floats IR transmit line
// - Serial mode resets to 0x02 both resets
// - Bit 0 selects receive polarity
// - Bit 1 selects transmit polarity
// - Bit 2 selects half or full duplex
// - Bits 5:3 select serial protocol mode
// - Bit 6 enables port 1 high speed
// - Bit 7 enables port 2 high speed
// - Device identity read-only, writes ignored
// - Revision register read-only silicon level
// - Test register resets zero, host leaves alone
module cfr_regs #(
    parameter logic [7:0] DEVICE_ID = 8'h5c, // Value arbitrary
    parameter logic [7:0] REVISION = 8'h01 // Value arbitrary
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hard_rst,
    input wire logic i_cfg_state,
    input wire logic i_index_wr,
    input wire logic i_index_rd,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rd_valid,
    output logic [cfr_pkg::ECP_THR_W-1:0] o_ecp_threshold,
    output logic [cfr_pkg::IR_SEL_W-1:0] o_ir_route_select,
    output logic o_rx_active_low,
    output logic o_tx_active_low,
    output logic o_half_duplex,
    output logic [cfr_pkg::MODE_W-1:0] o_uart2_mode,
    output logic o_uart1_high_speed,
    output logic o_uart2_high_speed,
    output logic [7:0] o_test_control,
    input wire logic i_uart2_powered,
    input wire logic i_uart2_tx,
    input wire logic i_ir_receive_line,
    output logic o_ir_transmit_line,
    output logic o_ir_transmit_line_oe,
    output logic o_uart2_rx
);
    import cfr_pkg::*;

    // ----------------------------------------
    // Access state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] rdata;
        logic rd_valid;
    } cfr_state_t;

    cfr_state_t st;
    cfr_state_t next_st;

    logic [7:0] ecp_threshold_ir_mux;
    logic [7:0] vendor_reserved_b;
    logic [7:0] serial_mode_config;
    logic [7:0] test_control_one;
    logic wr_ok;
    logic we_ecp_ir;
    logic we_vendor_b;
    logic we_serial;
    logic we_test;
    logic [7:0] read_mux;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // A data write strobe outside config state is dropped here
    assign wr_ok = i_cfg_state & i_data_wr;
    assign we_ecp_ir = wr_ok & (st.index == IDX_ECP_IR);
    assign we_vendor_b = wr_ok & (st.index == IDX_VENDOR_B);
    assign we_serial = wr_ok & (st.index == IDX_SERIAL);
    assign we_test = wr_ok & (st.index == IDX_TEST_ONE);

    always_comb begin
        case (st.index)
            IDX_ECP_IR: begin
                read_mux = ecp_threshold_ir_mux;
            end
            IDX_VENDOR_B: begin
                read_mux = vendor_reserved_b;
            end
            IDX_SERIAL: begin
                read_mux = serial_mode_config;
            end
            IDX_DEV_ID: begin
                read_mux = DEVICE_ID;
            end
            IDX_REVISION: begin
                read_mux = REVISION;
            end
            IDX_TEST_ONE: begin
                read_mux = test_control_one;
            end
            default: begin
                // Other indices belong to neighbouring slices
                read_mux = READ_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Index register and read path
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        if (i_cfg_state && i_index_wr) begin
            next_st.index = i_wdata;
        end
        if (i_cfg_state && i_index_rd) begin
            next_st.rdata = st.index;
            next_st.rd_valid = 1'b1;
        end else if (i_cfg_state && i_data_rd) begin
            next_st.rdata = read_mux;
            next_st.rd_valid = 1'b1;
        end else if (!i_cfg_state) begin
            // No stale register data is left on the bus
            next_st.rdata = READ_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '{index: RST_INDEX, rdata: READ_IDLE, rd_valid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_rd_valid = st.rd_valid;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Reserved bits masked from writes so they stay zero
    cfr_byte_reg #(
        .POR_VALUE(RST_ZERO),
        .WR_MASK(WMASK_ECP_IR),
        .HARD_MASK(HMASK_ECP_IR)
    ) u_ecp_ir (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hard_rst(i_hard_rst),
        .i_we(we_ecp_ir),
        .i_wdata(i_wdata),
        .o_q(ecp_threshold_ir_mux)
    );

    // Host is expected to leave this one alone
    cfr_byte_reg #(
        .POR_VALUE(RST_ZERO),
        .WR_MASK(WMASK_ALL),
        .HARD_MASK(HMASK_NONE)
    ) u_vendor_b (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hard_rst(i_hard_rst),
        .i_we(we_vendor_b),
        .i_wdata(i_wdata),
        .o_q(vendor_reserved_b)
    );

    cfr_byte_reg #(
        .POR_VALUE(RST_SERIAL),
        .WR_MASK(WMASK_ALL),
        .HARD_MASK(HMASK_ALL)
    ) u_serial (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hard_rst(i_hard_rst),
        .i_we(we_serial),
        .i_wdata(i_wdata),
        .o_q(serial_mode_config)
    );

    // Stored only; no test mode is wired to anything
    cfr_byte_reg #(
        .POR_VALUE(RST_ZERO),
        .WR_MASK(WMASK_ALL),
        .HARD_MASK(HMASK_NONE)
    ) u_test (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hard_rst(i_hard_rst),
        .i_we(we_test),
        .i_wdata(i_wdata),
        .o_q(test_control_one)
    );

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    assign o_ecp_threshold = ecp_threshold_ir_mux[ECP_THR_LSB +: ECP_THR_W];
    assign o_ir_route_select = ecp_threshold_ir_mux[IR_SEL_LSB +: IR_SEL_W];
    assign o_rx_active_low = serial_mode_config[RX_POL_BIT];
    assign o_tx_active_low = serial_mode_config[TX_POL_BIT];
    assign o_half_duplex = serial_mode_config[DUPLEX_BIT];
    assign o_uart2_mode = serial_mode_config[MODE_LSB +: MODE_W];
    assign o_uart1_high_speed = serial_mode_config[HS1_BIT];
    assign o_uart2_high_speed = serial_mode_config[HS2_BIT];
    assign o_test_control = test_control_one;

    // ----------------------------------------
    // Infrared pin stage
    // ----------------------------------------
    // One cycle of latency keeps the pin straight off a flop
    cfr_ir_route u_ir (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ir_route_select(ecp_threshold_ir_mux[IR_SEL_LSB +: IR_SEL_W]),
        .i_rx_active_low(serial_mode_config[RX_POL_BIT]),
        .i_tx_active_low(serial_mode_config[TX_POL_BIT]),
        .i_uart2_powered(i_uart2_powered),
        .i_uart2_tx(i_uart2_tx),
        .i_ir_receive_line(i_ir_receive_line),
        .o_ir_transmit_line(o_ir_transmit_line),
        .o_ir_transmit_line_oe(o_ir_transmit_line_oe),
        .o_uart2_rx(o_uart2_rx)
    );
endmodule
`default_nettype wire

// [tb/cfr_regs_properties.sv]
// Port assertions for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module cfr_regs_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hard_rst,
    input wire logic i_cfg_state,
    input wire logic i_index_rd,
    input wire logic i_data_rd,
    input wire logic i_uart2_powered,
    input wire logic i_uart2_tx,
    input wire logic i_ir_receive_line,
    input wire logic o_rd_valid,
    input wire logic [cfr_pkg::ECP_THR_W-1:0] o_ecp_threshold,
    input wire logic [cfr_pkg::IR_SEL_W-1:0] o_ir_route_select,
    input wire logic o_rx_active_low,
    input wire logic o_tx_active_low,
    input wire logic o_half_duplex,
    input wire logic [cfr_pkg::MODE_W-1:0] o_uart2_mode,
    input wire logic o_uart1_high_speed,
    input wire logic o_uart2_high_speed,
    input wire logic [7:0] o_test_control,
    input wire logic o_ir_transmit_line,
    input wire logic o_ir_transmit_line_oe,
    input wire logic o_uart2_rx
);
    import cfr_pkg::*;
    logic [7:0] ser;
    assign ser = {o_uart2_high_speed, o_uart1_high_speed, o_uart2_mode, o_half_duplex, o_tx_active_low,
        o_rx_active_low};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rd_ans;
        i_cfg_state && (i_index_rd || i_data_rd) |=> o_rd_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_cause;
        o_rd_valid |-> $past(i_cfg_state) && ($past(i_index_rd) || $past(i_data_rd));
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
    // Reset itself must be watched, so no disable here
    property p_por;
        disable iff (1'b0) i_rst |=> o_ecp_threshold == 4'h0 && o_ir_route_select == 2'h0
            && o_test_control == 8'h00 && ser == 8'h02 && !o_rd_valid;
    endproperty
    a_por: assert property (p_por) else $error("power-on values wrong");
    property p_hard;
        i_hard_rst |=> o_ir_route_select == 2'h0 && ser == 8'h02;
    endproperty
    a_hard: assert property (p_hard) else $error("hardware reset values wrong");
    property p_float;
        o_ir_route_select == 2'h3 |=> !o_ir_transmit_line_oe;
    endproperty
    a_float: assert property (p_float) else $error("transmit line driven while floated");
    property p_down;
        o_ir_route_select == 2'h1 && !i_uart2_powered |=> o_ir_transmit_line_oe && !o_ir_transmit_line;
    endproperty
    a_down: assert property (p_down) else $error("powered-down transmit not low");
    property p_tx;
        o_ir_route_select == 2'h1 && i_uart2_powered |=> o_ir_transmit_line_oe
            && o_ir_transmit_line == ($past(i_uart2_tx) ^ $past(o_tx_active_low));
    endproperty
    a_tx: assert property (p_tx) else $error("transmit polarity wrong");
    property p_rx;
        !i_rst |=> o_uart2_rx == ($past(i_ir_receive_line) ^ $past(o_rx_active_low));
    endproperty
    a_rx: assert property (p_rx) else $error("receive polarity wrong");
endmodule
bind cfr_regs cfr_regs_properties u_props (.i_clk, .i_rst, .i_hard_rst, .i_cfg_state, .i_index_rd,
    .i_data_rd, .i_uart2_powered, .i_uart2_tx, .i_ir_receive_line, .o_rd_valid, .o_ecp_threshold,
    .o_ir_route_select, .o_rx_active_low, .o_tx_active_low, .o_half_duplex, .o_uart2_mode,
    .o_uart1_high_speed, .o_uart2_high_speed, .o_test_control, .o_ir_transmit_line,
    .o_ir_transmit_line_oe, .o_uart2_rx);
`default_nettype wire

// [tb/cfr_host.sv]
// Host model driving the configuration index and data ports
`timescale 1ns/1ps
`default_nettype none
module cfr_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rd_valid,
    output logic o_cfg_state,
    output logic o_index_wr,
    output logic o_index_rd,
    output logic o_data_wr,
    output logic o_data_rd,
    output logic [7:0] o_wdata
);
    initial begin
        {o_cfg_state, o_index_wr, o_index_rd, o_data_wr, o_data_rd} = 5'h00;
        o_wdata = 8'h00;
    end
    // Strobes as {index_wr, index_rd, data_wr, data_rd}
    task automatic drive(input logic [3:0] s, input logic [7:0] d);
        @(posedge i_clk);
        {o_index_wr, o_index_rd, o_data_wr, o_data_rd} <= s;
        // Idle data bus toggles so a stale byte never looks valid
        o_wdata <= (s[3] || s[1]) ? d : ~o_wdata;
    endtask
    // Strobe for one edge, answer sampled after the following edge
    task automatic rd(input logic port, output logic [7:0] q, output logic v);
        drive(port ? 4'h4 : 4'h1, 8'h00);
        drive(4'h0, 8'h00);
        #1;
        q = i_rdata;
        v = i_rd_valid;
    endtask
    task automatic set_cfg(input logic b);
        @(posedge i_clk);
        o_cfg_state <= b;
    endtask
endmodule
`default_nettype wire

// [tb/test_cfr_regs.sv]
// Self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module test_cfr_regs;
    import cfr_pkg::*;
    localparam logic [7:0] DEV_ID = 8'ha7; // Value arbitrary
    localparam logic [7:0] REV_ID = 8'h03; // Value arbitrary
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_hard_rst = 1'b0;
    logic i_uart2_powered = 1'b0;
    logic i_uart2_tx = 1'b0;
    logic i_ir_receive_line = 1'b0;
    logic i_cfg_state, i_index_wr, i_index_rd, i_data_wr, i_data_rd, o_rd_valid, cfg_on;
    logic [7:0] i_wdata, o_rdata, o_test_control, ser;
    logic [ECP_THR_W-1:0] o_ecp_threshold;
    logic [IR_SEL_W-1:0] o_ir_route_select;
    logic [MODE_W-1:0] o_uart2_mode;
    logic o_rx_active_low, o_tx_active_low, o_half_duplex, o_uart1_high_speed, o_uart2_high_speed;
    logic o_ir_transmit_line, o_ir_transmit_line_oe, o_uart2_rx;
    logic [7:0] mdl [16];
    logic [7:0] ia [7] = '{8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h08, 8'h10};
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 26120;
    int cycles = 0;
    assign ser = {o_uart2_high_speed, o_uart1_high_speed, o_uart2_mode, o_half_duplex, o_tx_active_low,
        o_rx_active_low};
    cfr_host u_host (.i_clk, .i_rdata(o_rdata), .i_rd_valid(o_rd_valid), .o_cfg_state(i_cfg_state),
        .o_index_wr(i_index_wr), .o_index_rd(i_index_rd), .o_data_wr(i_data_wr), .o_data_rd(i_data_rd),
        .o_wdata(i_wdata));
    cfr_regs #(.DEVICE_ID(DEV_ID), .REVISION(REV_ID)) u_dut (.i_clk, .i_rst, .i_hard_rst, .i_cfg_state,
        .i_index_wr, .i_index_rd, .i_data_wr, .i_data_rd, .i_wdata, .o_rdata, .o_rd_valid, .o_ecp_threshold,
        .o_ir_route_select, .o_rx_active_low, .o_tx_active_low, .o_half_duplex, .o_uart2_mode,
        .o_uart1_high_speed, .o_uart2_high_speed, .o_test_control, .i_uart2_powered, .i_uart2_tx,
        .i_ir_receive_line, .o_ir_transmit_line, .o_ir_transmit_line_oe, .o_uart2_rx);
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    function automatic logic [7:0] exp_rd(input logic [7:0] idx);
        if (idx == 8'h0d) return DEV_ID;
        if (idx == 8'h0e) return REV_ID;
        if (idx >= 8'h0a && idx <= 8'h0f) return mdl[idx[3:0]];
        return 8'h00;
    endfunction
    task automatic end_sim;
        $display("Checked %0d samples, %0d errors", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        u_host.drive(4'h8, idx);
        u_host.drive(4'h2, d);
        u_host.drive(4'h0, 8'h00);
        if (cfg_on && idx >= 8'h0a && idx <= 8'h0f && idx != 8'h0d && idx != 8'h0e)
            mdl[idx[3:0]] = (idx == 8'h0a) ? d & 8'hcf : d;
    endtask
    task automatic rdchk(input logic [7:0] idx);
        logic [7:0] q;
        logic v;
        u_host.drive(4'h8, idx);
        u_host.rd(1'b0, q, v);
        chk("rd_valid", {7'h00, v}, {7'h00, cfg_on});
        chk("rdata", q, cfg_on ? exp_rd(idx) : 8'h00);
        chk("ecp_ir", {o_ir_route_select, 2'h0, o_ecp_threshold}, mdl[10]);
        chk("serial", ser, mdl[12]);
        chk("test", o_test_control, mdl[15]);
    endtask
    task automatic por(input int n);
        i_rst <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_rst <= 1'b0;
        mdl = '{default: 8'h00};
        mdl[12] = 8'h02;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_sim;
        end
    end
    initial begin
        logic [7:0] q, idx, d, e;
        logic v, tx, pw, rx;
        cfg_on = 1'b0;
        por(6);
        u_host.set_cfg(1'b1);
        cfg_on = 1'b1;
        for (int i = 8; i < 17; i++) rdchk(8'(i));
        u_host.drive(4'h8, 8'h0e);
        u_host.rd(1'b1, q, v);
        chk("index", q, 8'h0e);
        for (int i = 0; i < 60; i++) begin
            idx = ia[$unsigned($random(seed)) % 7];
            d = 8'($random(seed));
            if (idx == 8'h0a) d[6] = 1'b1;
            wr(idx, (idx == 8'h0f) ? 8'h00 : d);
            rdchk(idx);
        end
        u_host.set_cfg(1'b0);
        cfg_on = 1'b0;
        wr(8'h0c, 8'hff);
        rdchk(8'h0c);
        u_host.set_cfg(1'b1);
        cfg_on = 1'b1;
        rdchk(8'h0c);
        wr(8'h0a, 8'hff);
        wr(8'h0c, 8'hd5);
        @(posedge i_clk) i_hard_rst <= 1'b1;
        @(posedge i_clk) i_hard_rst <= 1'b0;
        mdl[10] = mdl[10] & 8'h3f;
        mdl[12] = 8'h02;
        rdchk(8'h0a);
        rdchk(8'h0c);
        for (int r = 1; r < 4; r += 2) begin
            wr(8'h0a, {r[1:0], 6'h05});
            wr(8'h0c, 8'($random(seed)) & 8'hc7);
            rdchk(8'h0c);
            repeat (12) begin
                tx = 1'($random(seed));
                pw = 1'($random(seed));
                rx = 1'($random(seed));
                @(posedge i_clk);
                i_uart2_tx <= tx;
                i_uart2_powered <= pw;
                i_ir_receive_line <= rx;
                @(posedge i_clk);
                #1;
                e = {5'h00, r == 1, (r == 1) && pw && (tx ^ mdl[12][1]), rx ^ mdl[12][0]};
                chk("ir", {5'h00, o_ir_transmit_line_oe, o_ir_transmit_line & o_ir_transmit_line_oe,
                    o_uart2_rx}, e);
            end
        end
        @(posedge i_clk);
        por(2);
        for (int i = 10; i < 16; i++) rdchk(8'(i));
        end_sim;
    end
endmodule
`default_nettype wire
